/* File: rtl/dsl_map.svh */
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH

// Serial word layout.
`define DSL_WORD_W 16
`define DSL_CODE_W 12
`define DSL_TGT_POS 15
`define DSL_SPEED_POS 14
`define DSL_PD_POS 13
`define DSL_BUFO_POS 12
`define DSL_CODE_MSB 11

// Bit counter of the counting variant.
`define DSL_BIT_COUNT 5'd16
`define DSL_CNT_W 5

// Reset values.
`define DSL_CODE_RST 12'h000

// Settling times in nanoseconds and their counts of system clock cycles.
`define DSL_CLK_NS 100
`define DSL_SLOW_NS 12500
`define DSL_FAST_NS 2500
`define DSL_SETTLE_W 8
`define DSL_SLOW_CYC 8'((`DSL_SLOW_NS) / (`DSL_CLK_NS))
`define DSL_FAST_CYC 8'((`DSL_FAST_NS) / (`DSL_CLK_NS))

`endif

/* File: rtl/dsl_pkg.sv */
`default_nettype none
`include "dsl_map.svh"

package dsl_pkg;

  // Kind of latch transfer chosen by the program bits.
  typedef enum logic [1:0] {xf_a_and_b, xf_b_and_buf, xf_buf_only} dsl_xfer_t;

  // Frame tracking in the system clock domain.
  typedef enum logic {st_idle, st_frame} dsl_state_t;

  // Received word split into its fields.
  typedef struct packed {
    logic target;
    logic speed;
    logic powerdown;
    logic buffer_only;
    logic [`DSL_CODE_W-1:0] code;
  } dsl_word_t;

endpackage

`default_nettype wire

/* File: rtl/dsl_link_if.sv */
`default_nettype none
`include "dsl_map.svh"

// Carries the shifted word and the end-of-write level out of the link domain.
interface dsl_link_if;
  logic [`DSL_WORD_W-1:0] word;
  logic end_lvl;
  modport shift (output word, output end_lvl);
  modport ctrl (input word, input end_lvl);
endinterface

`default_nettype wire

/* File: rtl/dsl_shift.sv */
`default_nettype none
`include "dsl_map.svh"

module dsl_shift #(
  parameter bit COUNTING = 1'b1 // Set for the variant that ends a write after 16 clocks.
) (
  input wire logic sclk, // Link shift clock from the host.
  input wire logic select_n, // Select pin, low during a write.
  input wire logic sdin, // Serial data pin.
  dsl_link_if.shift lnk // Word and end level toward the control domain.
);

  logic [`DSL_WORD_W-1:0] word_ff;
  logic [`DSL_CNT_W-1:0] bit_cnt_ff;
  logic cnt_done;

  // The counter is held clear while select is high, so each falling select starts at zero.
  always_ff @(negedge sclk or posedge select_n)
  begin
    if (select_n)
      bit_cnt_ff <= '0;
    else if (!cnt_done)
      bit_cnt_ff <= bit_cnt_ff + `DSL_CNT_W'(1);
  end

  // Counting stops shifting after sixteen falling edges until select falls again.
  assign cnt_done = COUNTING && (bit_cnt_ff == `DSL_BIT_COUNT);

  // Data is taken on the falling clock edge, first bit ending up in the top position.
  always_ff @(negedge sclk)
  begin
    if (!select_n && !cnt_done)
      word_ff <= {word_ff[`DSL_WORD_W-2:0], sdin};
  end

  // Either the select pin or the internal count ends the write.
  assign lnk.end_lvl = select_n | cnt_done;
  assign lnk.word = word_ff;

  // Each accepted bit lands in the lowest position of the word.
  a_shift_new_bit: assert property (@(negedge sclk) disable iff (select_n)
    (!cnt_done) |=> (word_ff[0] == $past(sdin)))
    else $error("shifted bit does not match sampled data");

  // A stopped counter or a high select leaves the word untouched.
  a_hold_when_off: assert property (@(negedge sclk)
    ((select_n || cnt_done) ##1 (select_n || cnt_done)) |-> $stable(word_ff))
    else $error("word changed while shifting was off");

endmodule // dsl_shift

`default_nettype wire

/* File: rtl/dsl_ctrl.sv */
//
// Overview of operation
// - Shift sixteen bits, top bit first, while selected.
// - Sample each data bit on falling clock.
// - Rising select performs the encoded latch transfer.
// - Select high ignores clocks, word held.
// - Bits 15-12 program, bits 11-0 code.
// - Target set: code to A, buffer to B.
// - Target clear, buffer-only clear: code to B, buffer.
// - Target clear, buffer-only set: buffer only.
// - Speed bit picks slow or fast settling.
// - Power-down bit sets power-down mode.
// - Counting variant stops after sixteen clocks.
// - Internal count end ORed with select.
// - Power-up clears the converter latches.
//
`default_nettype none
`include "dsl_map.svh"

module dsl_ctrl #(
  parameter bit COUNTING = 1'b1, // Set for the variant with the sixteen-clock counter.
  parameter int CODE_W = `DSL_CODE_W, // Converter code width.
  parameter int WORD_W = `DSL_WORD_W // Serial word width.
) (
  input wire logic mclk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes system-domain state when low.
  input wire logic sclk, // Serial shift clock from the host.
  input wire logic select_n, // Select pin from the host, active low.
  input wire logic sdin, // Serial data pin from the host.
  output logic [CODE_W-1:0] latch_a_code, // Channel A latch.
  output logic [CODE_W-1:0] latch_b_code, // Channel B latch.
  output logic [CODE_W-1:0] dbuf_code, // Double buffer contents.
  output logic fast_settle, // High selects fast settling.
  output logic power_down, // High puts the converter in power-down.
  output logic settling, // High while the selected settling time runs.
  output logic xfer_pulse, // One-cycle pulse after each transfer.
  output logic frame_active // High while a write is in progress.
);

  // Widths the logic is built for.
  generate
    if (CODE_W != `DSL_CODE_W || WORD_W != CODE_W + 4)
    begin : g_bad_width
      $error("dsl_ctrl supports a 12-bit code in a 16-bit word only");
    end
  endgenerate

  // Chooses the transfer kind from the target and buffer-only bits.
  function automatic dsl_pkg::dsl_xfer_t dsl_decode(input logic tgt, input logic bufo);
    dsl_pkg::dsl_xfer_t kind;
    kind = dsl_pkg::xf_buf_only;
    if (tgt)
      kind = dsl_pkg::xf_a_and_b;
    else if (!bufo)
      kind = dsl_pkg::xf_b_and_buf;
    else
      kind = dsl_pkg::xf_buf_only;
    return kind;
  endfunction

  dsl_link_if lnk ();

  logic [1:0] rst_pipe_ff;
  logic rst_n;
  logic end_meta_ff;
  logic end_sync_ff;
  dsl_pkg::dsl_state_t state_ff;
  dsl_pkg::dsl_state_t nxt_state;
  dsl_pkg::dsl_word_t word_in;
  dsl_pkg::dsl_xfer_t xfer_kind;
  logic xfer_now;
  logic moves_latch;
  logic [CODE_W-1:0] latch_a_ff;
  logic [CODE_W-1:0] latch_b_ff;
  logic [CODE_W-1:0] dbuf_ff;
  logic fast_ff;
  logic pd_ff;
  logic xfer_ff;
  logic moved_ff;
  logic [`DSL_SETTLE_W-1:0] settle_cnt_ff;
  logic [`DSL_SETTLE_W-1:0] nxt_settle_cnt;

  // Link-domain shifter; it runs on the host's shift clock.
  dsl_shift #(
    .COUNTING(COUNTING)
  ) u_shift (
    .sclk(sclk),
    .select_n(select_n),
    .sdin(sdin),
    .lnk(lnk.shift)
  );

  // Reset release is synchronised so that all system-domain flops leave reset together.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_pipe_ff <= 2'h0;
    else
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
  end

  assign rst_n = rst_pipe_ff[1];

  // Two-flop synchroniser for the end-of-write level; it idles high so reset makes no transfer.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      end_meta_ff <= 1'b1;
      end_sync_ff <= 1'b1;
    end
    else if (ce)
    begin
      end_meta_ff <= lnk.end_lvl;
      end_sync_ff <= end_meta_ff;
    end
  end

  // Frame tracking: a low end level opens a frame, its return high closes it.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      dsl_pkg::st_idle:
        if (!end_sync_ff)
          nxt_state = dsl_pkg::st_frame;
      dsl_pkg::st_frame:
        if (end_sync_ff)
          nxt_state = dsl_pkg::st_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= dsl_pkg::st_idle;
    else if (ce)
      state_ff <= nxt_state;
  end

  // The word is stable here because the shifter ignores clocks once the write has ended.
  assign word_in = dsl_pkg::dsl_word_t'(lnk.word);
  assign xfer_now = (state_ff == dsl_pkg::st_frame) && end_sync_ff;
  assign xfer_kind = dsl_decode(word_in.target, word_in.buffer_only);
  assign moves_latch = (xfer_kind != dsl_pkg::xf_buf_only);

  // Channel A latch takes the code only on a target write.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      latch_a_ff <= `DSL_CODE_RST;
    else if (ce && xfer_now && xfer_kind == dsl_pkg::xf_a_and_b)
      latch_a_ff <= word_in.code;
  end

  // Channel B latch takes the buffer on a target write and the code on a B write.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      latch_b_ff <= `DSL_CODE_RST;
    else if (ce && xfer_now)
    begin
      unique case (xfer_kind)
        dsl_pkg::xf_a_and_b:
          latch_b_ff <= dbuf_ff;
        dsl_pkg::xf_b_and_buf:
          latch_b_ff <= word_in.code;
        dsl_pkg::xf_buf_only:
          latch_b_ff <= latch_b_ff;
        default:
          latch_b_ff <= latch_b_ff;
      endcase
    end
  end

  // Double buffer takes the code on any write that does not target channel A.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dbuf_ff <= `DSL_CODE_RST;
    else if (ce && xfer_now && xfer_kind != dsl_pkg::xf_a_and_b)
      dbuf_ff <= word_in.code;
  end

  // Speed and power-down follow every write, whatever its transfer kind.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_ff <= 1'b0;
      pd_ff <= 1'b0;
    end
    else if (ce && xfer_now)
    begin
      fast_ff <= word_in.speed;
      pd_ff <= word_in.powerdown;
    end
  end

  // Settling window restarts on any write that moves a channel latch.
  always_comb
  begin
    nxt_settle_cnt = settle_cnt_ff;
    if (xfer_now && moves_latch)
      nxt_settle_cnt = word_in.speed ? `DSL_FAST_CYC : `DSL_SLOW_CYC;
    else if (settle_cnt_ff != '0)
      nxt_settle_cnt = settle_cnt_ff - `DSL_SETTLE_W'(1);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      settle_cnt_ff <= '0;
    else if (ce)
      settle_cnt_ff <= nxt_settle_cnt;
  end

  // Transfer strobe and whether the transfer moved a channel latch.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_ff <= 1'b0;
      moved_ff <= 1'b0;
    end
    else if (ce)
    begin
      xfer_ff <= xfer_now;
      moved_ff <= xfer_now && moves_latch;
    end
  end

  // Outputs come from flops; settling is the nonzero test of the settling counter.
  assign latch_a_code = latch_a_ff;
  assign latch_b_code = latch_b_ff;
  assign dbuf_code = dbuf_ff;
  assign fast_settle = fast_ff;
  assign power_down = pd_ff;
  assign settling = (settle_cnt_ff != '0);
  assign xfer_pulse = xfer_ff;
  assign frame_active = (state_ff == dsl_pkg::st_frame);

  // A closed frame gives a transfer strobe on the following cycle.
  a_end_gives_xfer: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    ((state_ff == dsl_pkg::st_frame) && end_sync_ff) |=> (xfer_pulse && !frame_active))
    else $error("end of write did not produce a transfer");

  // No transfer without a frame that was open the cycle before.
  a_xfer_needs_frame: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(xfer_pulse) |-> $past(frame_active))
    else $error("transfer without an open frame");

  // Target write: code to A, old buffer to B, buffer kept.
  a_latch_a_write: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (xfer_now && word_in.target) |=>
      (latch_a_code == $past(word_in.code)) && (latch_b_code == $past(dbuf_code))
      && $stable(dbuf_code))
    else $error("channel A write moved the wrong latches");

  // B write: code to B and buffer, A kept.
  a_latch_b_write: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (xfer_now && !word_in.target && !word_in.buffer_only) |=>
      (latch_b_code == $past(word_in.code)) && (dbuf_code == $past(word_in.code))
      && $stable(latch_a_code))
    else $error("channel B write moved the wrong latches");

  // Buffer-only write: both channel latches kept.
  a_buffer_only: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (xfer_now && !word_in.target && word_in.buffer_only) |=>
      (dbuf_code == $past(word_in.code)) && $stable(latch_a_code) && $stable(latch_b_code))
    else $error("buffer-only write disturbed a channel latch");

  // Speed output matches the last written speed bit.
  a_speed_follows: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    xfer_now |=> (fast_settle == $past(word_in.speed))
      && (settling || !$past(moves_latch)))
    else $error("speed selection not applied by the write");

  // Fast settling holds for at least eight cycles after a moving write.
  a_fast_settle: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (moved_ff && fast_settle) |-> settling[*8])
    else $error("fast settling window too short");

  // Settling never exceeds the slow window.
  a_settle_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    settle_cnt_ff <= `DSL_SLOW_CYC)
    else $error("settling counter beyond slow window");

  // Power-down output matches the last written power-down bit.
  a_power_mode: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    xfer_now |=> (power_down == $past(word_in.powerdown)))
    else $error("power-down bit not applied by the write");

  // Latches leave reset at zero.
  a_reset_zero: assert property (@(posedge mclk)
    $rose(rst_n) |-> (latch_a_code == '0) && (latch_b_code == '0) && (dbuf_code == '0))
    else $error("latches not cleared by reset");

  // Transfer strobe lasts a single cycle.
  a_pulse_single: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    xfer_pulse |=> !xfer_pulse)
    else $error("transfer strobe longer than one cycle");

  // A frame opens only after the synchronised end level has gone low.
  a_frame_opens: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    $rose(frame_active) |-> $past(!end_sync_ff))
    else $error("frame opened without a low end level");

  // A low end level keeps the frame open.
  a_frame_holds: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (frame_active && !end_sync_ff) |=> frame_active)
    else $error("frame closed while the end level was low");

  // A moving write reloads the settling window for the written speed.
  a_settle_load: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (xfer_now && moves_latch) |=>
      (settle_cnt_ff == ($past(word_in.speed) ? `DSL_FAST_CYC : `DSL_SLOW_CYC)))
    else $error("settling window not reloaded by the write");

  // A buffer-only write never starts a settling window.
  a_bufo_no_settle: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    (xfer_now && !moves_latch && !settling) |=> !settling)
    else $error("buffer-only write started settling");

  // Speed and power-down bits hold between writes.
  a_mode_holds: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
    !xfer_now |=> $stable(fast_settle) && $stable(power_down))
    else $error("mode bits changed without a write");

  // A low enable freezes every system-domain register except the reset synchroniser, so no transfer can happen.
  a_ce_freeze: assert property (@(posedge mclk) disable iff (!rst_n)
    !ce |=> $stable(state_ff) && $stable(settle_cnt_ff) && $stable(latch_a_ff)
      && $stable(latch_b_ff) && $stable(dbuf_ff) && $stable(xfer_ff))
    else $error("state changed while the clock enable was low");

endmodule // dsl_ctrl

`default_nettype wire

/* File: test/dsl_host_model.sv */
`default_nettype none

// Host serial controller: drives select, shift clock and data for each write.
module dsl_host_model (
  output logic select_n, // Select, low during a write.
  output logic sclk, // Shift clock, high and still when idle.
  output logic sdin // Serial data.
);
  timeunit 1ns;
  timeprecision 1ns;

  // Half period of the 80 ns shift clock.
  localparam int HALF = 40;

  // Idle levels before the first write.
  initial
  begin
    select_n = 1'b1;
    sclk = 1'b1;
    sdin = 1'b0;
  end

  // Sends the low n bits of a value, top bit first; a nonzero gap pauses after the first eight bits.
  task automatic frame(input logic [31:0] bits, input int n, input int gap);
    int i;
    #37;
    select_n = 1'b0;
    #(HALF);
    for (i = 0; i < n; i++)
    begin
      sdin = bits[n-1-i];
      #(HALF) sclk = 1'b0;
      #(HALF) sclk = 1'b1;
      if (i == 7 && gap > 0)
        #(gap);
    end
    #20 select_n = 1'b1;
    sdin = ~sdin; // Released data line shows no stale value.
    #500;
  endtask

  // Clock edges with select high, which must be ignored.
  task automatic stray(input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      sdin = 1'($urandom);
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #300;
  endtask
endmodule // dsl_host_model

`default_nettype wire

/* File: test/tb_top.sv */
`default_nettype none

// Self-checking bench for the serial latch control, counting variant.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk;
  logic nrst;
  logic ce;
  logic select_n;
  logic sclk;
  logic sdin;
  logic [11:0] latch_a_code;
  logic [11:0] latch_b_code;
  logic [11:0] dbuf_code;
  logic fast_settle;
  logic power_down;
  logic settling;
  logic xfer_pulse;
  logic frame_active;
  logic [11:0] ea;
  logic [11:0] eb;
  logic [11:0] ebuf;
  logic ef;
  logic ep;
  logic [15:0] sw;
  logic [31:0] r;
  int mismatches;
  int num_checks;
  int n_xfer;
  int n_settle;
  int n_base;
  int i;
  logic seen_frame;

  dsl_ctrl #(.COUNTING(1'b1)) dut_u (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .sclk(sclk),
    .select_n(select_n),
    .sdin(sdin),
    .latch_a_code(latch_a_code),
    .latch_b_code(latch_b_code),
    .dbuf_code(dbuf_code),
    .fast_settle(fast_settle),
    .power_down(power_down),
    .settling(settling),
    .xfer_pulse(xfer_pulse),
    .frame_active(frame_active)
  );

  dsl_host_model host_u (
    .select_n(select_n),
    .sclk(sclk),
    .sdin(sdin)
  );

  // System clock of 100 ns.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Counts transfer pulses and cycles spent settling, and notes any open frame.
  always @(posedge mclk)
  begin
    if (xfer_pulse === 1'b1)
      n_xfer++;
    if (settling === 1'b1)
      n_settle++;
    if (frame_active === 1'b1)
      seen_frame = 1'b1;
  end

  // Compares one value and reports a difference.
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Expected latch contents after one transfer of word w.
  function automatic void model(input logic [15:0] w);
    if (w[15])
    begin
      ea = w[11:0];
      eb = ebuf;
    end
    else if (!w[12])
    begin
      eb = w[11:0];
      ebuf = w[11:0];
    end
    else
      ebuf = w[11:0];
    ef = w[14];
    ep = w[13];
  endfunction

  // Resets the design and checks the cleared state.
  task automatic do_reset;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
    {ea, eb, ebuf, ef, ep} = '0;
    chk(48'({latch_a_code, latch_b_code, dbuf_code}), 48'h0);
    chk(48'({fast_settle, power_down, settling}), 48'h0);
    $display("reset test done");
  endtask

  // One write of n bits, then a check of every output against the model.
  task automatic write(input logic [31:0] bits, input int n, input int gap);
    int t;
    int k;
    logic [15:0] w;
    t = n_xfer + 1;
    if (n >= 16)
      w = 16'(bits >> (n - 16));
    else
      w = 16'((32'(sw) << n) | bits);
    sw = w;
    model(w);
    n_settle = 0;
    seen_frame = 1'b0;
    host_u.frame(bits, n, gap);
    for (k = 0; k < 200 && n_xfer < t; k++)
      @(posedge mclk);
    if (n_xfer < t)
    begin
      chk(48'(n_xfer), 48'(t));
      tally_and_finish;
    end
    repeat (140) @(posedge mclk);
    chk(48'(n_xfer), 48'(t));
    chk(48'(latch_a_code), 48'(ea));
    chk(48'(latch_b_code), 48'(eb));
    chk(48'(dbuf_code), 48'(ebuf));
    chk(48'({fast_settle, power_down}), 48'({ef, ep}));
    chk(48'(n_settle), 48'((w[15] | !w[12]) ? (w[14] ? 25 : 125) : 0));
    chk(48'({seen_frame, frame_active}), 48'h2);
    $display("write test done, word %h", w);
  endtask

  // Main sequence: corner cases, random writes, clock enable and a second reset.
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    mismatches = 0;
    num_checks = 0;
    n_xfer = 0;
    n_settle = 0;
    sw = 16'h0;
    void'($urandom(32'h1f3d));
    do_reset;
    write(32'h5fff, 16, 0);
    write(32'hc800, 16, 0);
    write(32'h2abc, 16, 300);
    write(32'hfedcb, 20, 0);
    host_u.stray(5);
    write(32'h9, 4, 0);
    for (i = 0; i < 24; i++)
    begin
      r = $urandom;
      r[14] = ef;
      write(r, 16, r[20] ? 120 : 0);
    end
    // A write made while the clock enable is low is never taken.
    @(posedge mclk);
    ce <= 1'b0;
    seen_frame = 1'b0;
    n_base = n_xfer;
    host_u.frame(32'h8abc, 16, 0);
    sw = 16'h8abc;
    @(posedge mclk);
    ce <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(48'(n_xfer), 48'(n_base));
    chk(48'(seen_frame), 48'h0);
    chk(48'({latch_a_code, latch_b_code, dbuf_code}), 48'({ea, eb, ebuf}));
    $display("clock enable test done");
    do_reset;
    write(32'h4123, 16, 0);
    tally_and_finish;
  end
endmodule // tb_top

`default_nettype wire
